/* File: logic/asi_pkg.sv */
package asi_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ERR_CODE = 8'h08;
  localparam logic [7:0] OFF_SYS_CODE = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  // ctrl fields
  localparam int unsigned CTRL_SERVO_OFF = 0;
  localparam int unsigned CTRL_ERR_RESET = 1;
  // irq fields
  localparam int unsigned IRQ_START_OK = 0;
  localparam int unsigned IRQ_START_ERR = 1;
  localparam int unsigned IRQ_SYS_ERR = 2;
  localparam int unsigned IRQ_SERVO_ERR = 3;
  localparam int unsigned IRQ_W = 4;
  // error codes
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_STOP = 16'h03E8;
  localparam logic [15:0] CODE_UPPER_LIMIT = 16'h03E9;
  localparam logic [15:0] CODE_LOWER_LIMIT = 16'h03EA;
  localparam logic [15:0] CODE_DOG_ON = 16'h03EB;
  localparam logic [15:0] CODE_NOT_READY = 16'h03EC;
  localparam logic [15:0] CODE_SERVO_ERR = 16'h03ED;
  localparam logic [15:0] CODE_START_LO = 16'h03E8;
  localparam logic [15:0] CODE_START_HI = 16'h044B;
  localparam logic [15:0] CODE_MAJOR_HI = 16'h07CF;
  localparam logic [15:0] CODE_TRAVEL = 16'h0385;
  // reset value and axi response codes
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_BUSY = 2'b11
  } asi_state_t;

  typedef enum logic [3:0] {
    MODE_POSITIONING = 4'h0,
    MODE_FIXED_PITCH = 4'h1,
    MODE_SPEED = 4'h2,
    MODE_SPEED_POSITION = 4'h3,
    MODE_SPEED_SWITCH = 4'h4,
    MODE_CONSTANT_SPEED = 4'h5,
    MODE_JOG = 4'h6,
    MODE_MANUAL_PULSE = 4'h7,
    MODE_HOME_DOG = 4'h8,
    MODE_HOME_OTHER = 4'h9,
    MODE_FOLLOW_UP = 4'hA,
    MODE_HIGH_SPEED_OSCILLATION = 4'hB,
    MODE_FIXED_STOP_SPEED = 4'hC
  } asi_mode_t;

  typedef struct packed {
    logic ext_stop;
    logic upper_limit_switch;
    logic lower_limit_switch;
    logic prox_dog;
    logic servo_ready;
    logic servo_error;
    logic travel_over;
  } asi_pins_t;

  typedef struct packed {
    logic req;
    logic dir_fwd;
    asi_mode_t mode;
  } asi_cmd_t;
endpackage : asi_pkg

/* File: logic/asi_top.sv */
`timescale 1ns/1ns
// Operation
// - command-driven errors are major errors coded 1000 to 1999.
// - start check failures use codes 1000 to 1099.
// - external stop active at start refuses start with code 1000.
// - forward start with upper limit switch off refuses with code 1001.
// - reverse start with lower limit switch off refuses with code 1002.
// - dog-type home return with dog already on refuses with code 1003.
// - servo ready flag off at start refuses with code 1004.
// - servo off command forces the ready flag off.
// - servo error flag set at start refuses with code 1005.
// - travel overrun reports code 901 and motion carries on.
module asi_top
  import asi_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // start command, same clock
  input wire asi_pkg::asi_cmd_t cmd,
  input wire logic motion_done,
  // field pins, asynchronous
  input wire asi_pkg::asi_pins_t pins_in,
  // axis status
  output logic start_accept,
  output logic start_ok,
  output logic start_err,
  output logic irq
);
  import asi_pkg::*;

  typedef struct packed {
    asi_state_t st;
    asi_pins_t s1;
    asi_pins_t s2;
    logic trv_d;
    logic dir_fwd;
    asi_mode_t mode;
    logic off_cmd;
    logic err_flag;
    logic accept;
    logic ok_p;
    logic err_p;
    logic [15:0] err_code;
    logic [15:0] sys_code;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } asi_regs_t;

  asi_regs_t r_reg;
  asi_regs_t r_next;

  // first failing check wins, in code order
  function automatic logic [15:0] asi_check(
    input asi_pins_t p,
    input logic ready,
    input logic err,
    input logic fwd,
    input asi_mode_t mode
  );
    logic [15:0] code;
    code = CODE_NONE;
    if (p.ext_stop) begin
      code = CODE_STOP;
    end else if (fwd && !p.upper_limit_switch) begin
      code = CODE_UPPER_LIMIT;
    end else if (!fwd && !p.lower_limit_switch) begin
      code = CODE_LOWER_LIMIT;
    end else if (mode == MODE_HOME_DOG && p.prox_dog) begin
      code = CODE_DOG_ON;
    end else if (!ready) begin
      code = CODE_NOT_READY;
    end else if (err) begin
      code = CODE_SERVO_ERR;
    end
    return code;
  endfunction : asi_check

  logic axis_servo_ready_flag;
  logic [15:0] chk_code;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic wr_do;
  logic err_reset;

  // the off command masks the amplifier's ready
  assign axis_servo_ready_flag = r_reg.s2.servo_ready & ~r_reg.off_cmd;
  assign chk_code = asi_check(r_reg.s2, axis_servo_ready_flag, r_reg.err_flag,
                              r_reg.dir_fwd, r_reg.mode);
  assign wr_do = r_reg.aw_got & r_reg.w_got;
  assign err_reset = wr_do && r_reg.awaddr == OFF_CTRL && r_reg.wstrb[0]
                     && r_reg.wdata[CTRL_ERR_RESET];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_next = r_reg;
    irq_set = '0;
    irq_clr = '0;
    r_next.s1 = pins_in;
    r_next.s2 = r_reg.s1;
    r_next.trv_d = r_reg.s2.travel_over;
    r_next.ok_p = 1'b0;
    r_next.err_p = 1'b0;

    // servo error flag is sticky; a new error beats a reset
    if (err_reset) begin
      r_next.err_flag = 1'b0;
    end
    if (r_reg.s2.servo_error) begin
      r_next.err_flag = 1'b1;
      irq_set[IRQ_SERVO_ERR] = ~r_reg.err_flag;
    end

    // travel overrun is logged only, the axis keeps its state
    if (r_reg.s2.travel_over && !r_reg.trv_d) begin
      r_next.sys_code = CODE_TRAVEL;
      irq_set[IRQ_SYS_ERR] = 1'b1;
    end

    case (r_reg.st)
      ST_IDLE: begin
        if (cmd.req) begin
          r_next.dir_fwd = cmd.dir_fwd;
          r_next.mode = cmd.mode;
          r_next.st = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (chk_code != CODE_NONE) begin
          r_next.err_code = chk_code;
          r_next.err_p = 1'b1;
          irq_set[IRQ_START_ERR] = 1'b1;
          r_next.st = ST_IDLE;
        end else begin
          r_next.accept = 1'b1;
          r_next.ok_p = 1'b1;
          irq_set[IRQ_START_OK] = 1'b1;
          r_next.st = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (motion_done) begin
          r_next.accept = 1'b0;
          r_next.st = ST_IDLE;
        end
      end
      default: begin
        r_next.accept = 1'b0;
        r_next.st = ST_IDLE;
      end
    endcase

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      r_next.aw_got = 1'b1;
      r_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_next.w_got = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (wr_do) begin
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = RESP_OKAY;
      case (r_reg.awaddr)
        OFF_CTRL: begin
          if (r_reg.wstrb[0]) begin
            r_next.off_cmd = r_reg.wdata[CTRL_SERVO_OFF];
          end
        end
        OFF_IRQ_STAT: begin
          if (r_reg.wstrb[0]) begin
            irq_clr = r_reg.wdata[IRQ_W-1:0];
          end
        end
        OFF_IRQ_MASK: begin
          if (r_reg.wstrb[0]) begin
            r_next.irq_mask = r_reg.wdata[IRQ_W-1:0];
          end
        end
        OFF_STATUS, OFF_ERR_CODE, OFF_SYS_CODE: begin
          r_next.bresp = RESP_OKAY;
        end
        default: begin
          r_next.bresp = RESP_SLVERR;
        end
      endcase
    end

    // write-one-to-clear, a same-cycle event wins
    r_next.irq_stat = (r_reg.irq_stat & ~irq_clr) | irq_set;

    // read channel: one cycle from address to data
    if (s_axi_rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = RESP_OKAY;
      r_next.rdata = '0;
      case (s_axi_araddr)
        OFF_CTRL: r_next.rdata[CTRL_SERVO_OFF] = r_reg.off_cmd;
        OFF_STATUS: r_next.rdata[12:0] = {r_reg.st, r_reg.accept, r_reg.err_flag,
                                         axis_servo_ready_flag, 1'b0, r_reg.s2};
        OFF_ERR_CODE: r_next.rdata[15:0] = r_reg.err_code;
        OFF_SYS_CODE: r_next.rdata[15:0] = r_reg.sys_code;
        OFF_IRQ_STAT: r_next.rdata[IRQ_W-1:0] = r_reg.irq_stat;
        OFF_IRQ_MASK: r_next.rdata[IRQ_W-1:0] = r_reg.irq_mask;
        default: r_next.rresp = RESP_SLVERR;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
      r_reg.irq_mask <= IRQ_MASK_RST;
      r_reg.err_code <= CODE_NONE;
      r_reg.sys_code <= CODE_NONE;
    end else begin
      r_reg <= r_next;
    end
  end

  // a write stalls until its response is taken, keeping one in flight
  assign s_axi_awready = ~r_reg.aw_got & ~r_reg.bvalid;
  assign s_axi_wready = ~r_reg.w_got & ~r_reg.bvalid;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = ~r_reg.rvalid;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;
  assign start_accept = r_reg.accept;
  assign start_ok = r_reg.ok_p;
  assign start_err = r_reg.err_p;
  assign irq = |(r_reg.irq_stat & r_reg.irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  logic pre_ok;
  assign pre_ok = !r_reg.s2.ext_stop
                  && (r_reg.dir_fwd ? r_reg.s2.upper_limit_switch
                                    : r_reg.s2.lower_limit_switch)
                  && !(r_reg.mode == MODE_HOME_DOG && r_reg.s2.prox_dog);

  a_stop_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.st == ST_CHECK && r_reg.s2.ext_stop
    |=> start_err && !start_accept && r_reg.err_code == CODE_STOP)
    else $error("stop input did not refuse the start");

  a_fwd_limit: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.st == ST_CHECK && !r_reg.s2.ext_stop && r_reg.dir_fwd
    && !r_reg.s2.upper_limit_switch
    |=> start_err && r_reg.err_code == CODE_UPPER_LIMIT)
    else $error("forward start past upper limit not refused");

  a_rev_limit: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.st == ST_CHECK && !r_reg.s2.ext_stop && !r_reg.dir_fwd
    && !r_reg.s2.lower_limit_switch
    |=> start_err && r_reg.err_code == CODE_LOWER_LIMIT)
    else $error("reverse start past lower limit not refused");

  a_dog_home: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.st == ST_CHECK && r_reg.s2.prox_dog && r_reg.mode != MODE_HOME_DOG
    && pre_ok && axis_servo_ready_flag && !r_reg.err_flag
    |=> start_ok ##1 start_accept)
    else $error("dog input blocked a start outside dog home return");

  a_off_ready: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.st == ST_CHECK && pre_ok && r_reg.off_cmd
    |=> start_err && r_reg.err_code == CODE_NOT_READY)
    else $error("servo off did not give the not-ready refusal");

  a_servo_err: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.st == ST_CHECK && pre_ok && axis_servo_ready_flag && r_reg.err_flag
    |=> start_err && r_reg.err_code == CODE_SERVO_ERR)
    else $error("servo error flag did not refuse the start");

  a_code_range: assert property (@(posedge aclk) disable iff (!aresetn)
    start_err |-> r_reg.err_code >= CODE_START_LO && r_reg.err_code <= CODE_START_HI
    && r_reg.err_code <= CODE_MAJOR_HI)
    else $error("start error code outside its range");

  a_refuse_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    start_err |-> !start_accept && r_reg.st == ST_IDLE
    && r_reg.err_code == $past(chk_code))
    else $error("refused start left the axis active");

  a_travel_run: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.st == ST_BUSY && r_reg.s2.travel_over && !r_reg.trv_d && !motion_done
    |=> r_reg.st == ST_BUSY && start_accept && r_reg.sys_code == CODE_TRAVEL)
    else $error("travel overrun stopped the axis or was not logged");

  a_dog_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.st == ST_CHECK && !r_reg.s2.ext_stop && r_reg.mode == MODE_HOME_DOG
    && r_reg.s2.prox_dog
    && (r_reg.dir_fwd ? r_reg.s2.upper_limit_switch : r_reg.s2.lower_limit_switch)
    |=> start_err && !start_accept && r_reg.err_code == CODE_DOG_ON)
    else $error("dog already on did not refuse the home return");

  a_err_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.s2.servo_error |=> r_reg.err_flag)
    else $error("servo error flag not set by the amplifier");

  a_ok_running: assert property (@(posedge aclk) disable iff (!aresetn)
    start_ok |-> start_accept && !start_err && r_reg.st == ST_BUSY)
    else $error("accepted start not shown as running");
endmodule : asi_top

/* File: verif/asi_field_model.sv */
`timescale 1ns/1ns
module asi_field_model
  import asi_pkg::*;
#(parameter int LAT = 2)
(
  // clock
  input wire logic aclk,
  // levels the bench wants on the field side
  input wire asi_pkg::asi_pins_t want,
  // field pins toward the block
  output asi_pkg::asi_pins_t pins_in
);
  asi_pins_t dly_q [LAT];
  // contacts and amplifier flags settle late, so the block must not trust a same-cycle level
  always_ff @(posedge aclk) begin
    dly_q[0] <= want;
    for (int i = 1; i < LAT; i++) begin
      dly_q[i] <= dly_q[i-1];
    end
  end
  // limit inputs high while the axis is inside its range
  assign pins_in = dly_q[LAT-1];
endmodule : asi_field_model

/* File: verif/tb.sv */
`timescale 1ns/1ns
module tb;
  import asi_pkg::*;
  logic aclk;
  logic aresetn;
  logic [7:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [7:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  asi_cmd_t cmd;
  logic motion_done;
  asi_pins_t want;
  asi_pins_t pins_in;
  logic start_accept;
  logic start_ok;
  logic start_err;
  logic irq;
  int fail_count;
  int checks_done;
  logic [31:0] rd;
  logic [1:0] rsp;
  asi_pins_t rp;
  logic rf;
  asi_mode_t rm;
  logic ro;
  localparam asi_pins_t CLEAN = 7'h34;

  asi_field_model #(.LAT(2)) asi_field_model_inst (.aclk, .want, .pins_in);
  asi_top asi_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd, .motion_done, .pins_in,
    .start_accept, .start_ok, .start_err, .irq);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_flag

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  // readies are sampled mid-cycle: inputs only move at the rising edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid & s_axi_awready;
      w_hs = s_axi_wvalid & s_axi_wready;
      b_hs = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
    end while (b_hs !== 1'b1);
    // a write that never answers is ended by the watchdog
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs;
    logic r_hs;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid & s_axi_arready;
      r_hs = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
    end while (r_hs !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    axi_read(a, rd, rsp);
    cmp_val(rd, e);
    cmp_val({30'h0, rsp}, {30'h0, er});
  endtask : rchk

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_code(asi_pins_t p, logic fwd, asi_mode_t m, logic off);
    if (p.ext_stop) return CODE_STOP;
    if (fwd && !p.upper_limit_switch) return CODE_UPPER_LIMIT;
    if (!fwd && !p.lower_limit_switch) return CODE_LOWER_LIMIT;
    if (m == MODE_HOME_DOG && p.prox_dog) return CODE_DOG_ON;
    if (!p.servo_ready || off) return CODE_NOT_READY;
    if (p.servo_error) return CODE_SERVO_ERR;
    return CODE_NONE;
  endfunction : exp_code

  // clear any sticky servo error first so each trial starts from a known flag
  task automatic prep(input asi_pins_t p, input logic off);
    @(posedge aclk);
    want <= CLEAN;
    tick(6);
    axi_write(OFF_CTRL, {30'h0, 1'b1, off}, rsp);
    want <= p;
    tick(6);
  endtask : prep

  task automatic go(input logic fwd, input asi_mode_t m, input logic [15:0] e);
    @(posedge aclk);
    cmd <= '{req: 1'b1, dir_fwd: fwd, mode: m};
    @(posedge aclk);
    cmd.req <= 1'b0;
    // the answer pulse stands for the single cycle after the check edge
    tick(1);
    #1;
    cmp_flag(start_ok, e === CODE_NONE);
    cmp_flag(start_err, e !== CODE_NONE);
    cmp_flag(start_accept, e === CODE_NONE);
    if (e === CODE_NONE) begin
      @(posedge aclk);
      motion_done <= 1'b1;
      @(posedge aclk);
      motion_done <= 1'b0;
      #1;
      cmp_flag(start_accept, 1'b0);
    end else begin
      rchk(OFF_ERR_CODE, {16'h0000, e}, RESP_OKAY);
      cmp_flag(rd[15:0] >= CODE_START_LO && rd <= {16'h0000, CODE_START_HI}, 1'b1);
    end
  endtask : go

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    #1_000_000;
    fail_count++;
    give_verdict();
  end

  initial begin
    {aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, motion_done} = '0;
    s_axi_wstrb = 4'hF;
    cmd = '0;
    want = CLEAN;
    fail_count = 0;
    checks_done = 0;
    void'($urandom(79));
    tick(3);
    aresetn <= 1'b1;
    rchk(OFF_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
    rchk(8'h20, 32'h0000_0000, RESP_SLVERR);
    rchk(OFF_STATUS, 32'h0000_0134, RESP_OKAY);
    axi_write(8'h20, 32'h0000_0001, rsp);
    cmp_val({30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_write(OFF_IRQ_MASK, 32'h0000_0000, rsp);
    cmp_val({30'h0, rsp}, {30'h0, RESP_OKAY});
    for (int m = 0; m < 13; m++) begin
      prep(CLEAN | 7'h40, 1'b0);
      go(1'(m), asi_mode_t'(m[3:0]), CODE_STOP);
    end
    prep(7'h14, 1'b0);
    go(1'b1, MODE_SPEED, CODE_UPPER_LIMIT);
    go(1'b0, MODE_SPEED, CODE_NONE);
    prep(7'h24, 1'b0);
    go(1'b0, MODE_JOG, CODE_LOWER_LIMIT);
    prep(7'h3C, 1'b0);
    go(1'b1, MODE_HOME_DOG, CODE_DOG_ON);
    go(1'b1, MODE_HOME_OTHER, CODE_NONE);
    prep(7'h30, 1'b0);
    go(1'b1, MODE_POSITIONING, CODE_NOT_READY);
    prep(CLEAN, 1'b1);
    rchk(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
    rchk(OFF_STATUS, 32'h0000_0034, RESP_OKAY);
    go(1'b0, MODE_SPEED, CODE_NOT_READY);
    prep(7'h36, 1'b0);
    go(1'b1, MODE_JOG, CODE_SERVO_ERR);
    @(posedge aclk);
    want <= CLEAN;
    tick(6);
    go(1'b1, MODE_JOG, CODE_SERVO_ERR);
    axi_write(OFF_CTRL, 32'h0000_0002, rsp);
    go(1'b1, MODE_JOG, CODE_NONE);
    // overrun arrives while the axis runs; it must keep running
    prep(CLEAN, 1'b0);
    @(posedge aclk);
    cmd <= '{req: 1'b1, dir_fwd: 1'b1, mode: MODE_SPEED};
    @(posedge aclk);
    cmd.req <= 1'b0;
    want <= CLEAN | 7'h01;
    tick(8);
    #1;
    cmp_flag(start_accept, 1'b1);
    rchk(OFF_SYS_CODE, {16'h0000, CODE_TRAVEL}, RESP_OKAY);
    @(posedge aclk);
    motion_done <= 1'b1;
    @(posedge aclk);
    motion_done <= 1'b0;
    go(1'b1, MODE_SPEED, CODE_NONE);
    repeat (30) begin
      rp = asi_pins_t'(CLEAN ^ 7'($urandom & $urandom));
      rf = 1'($urandom);
      rm = asi_mode_t'(4'($urandom % 13));
      ro = (($urandom % 4) == 0);
      prep(rp, ro);
      go(rf, rm, exp_code(rp, rf, rm, ro));
    end
    rchk(OFF_IRQ_STAT, 32'h0000_000F, RESP_OKAY);
    cmp_flag(irq, 1'b0);
    axi_write(OFF_IRQ_MASK, 32'h0000_0002, rsp);
    #1;
    cmp_flag(irq, 1'b1);
    axi_write(OFF_IRQ_STAT, 32'h0000_0002, rsp);
    #1;
    cmp_flag(irq, 1'b0);
    rchk(OFF_IRQ_STAT, 32'h0000_000D, RESP_OKAY);
    give_verdict();
  end
endmodule : tb
